// ### spg_pkg.sv
// Constants shared by the switch PWM and pin-function configuration block.
package spg_pkg;

    // ============================================================
    // Clock and timing
    localparam int unsigned CLK_HZ          = 250_000_000;
    localparam int unsigned PWM_STEPS       = 255;
    localparam int unsigned PWM_RATE_LO_HZ  = 200;
    localparam int unsigned PWM_RATE_HI_HZ  = 400;
    localparam int unsigned PWM_STEP_LO_CYC = CLK_HZ / (PWM_RATE_LO_HZ * PWM_STEPS);
    localparam int unsigned PWM_STEP_HI_CYC = CLK_HZ / (PWM_RATE_HI_HZ * PWM_STEPS);
    localparam int unsigned WAKE_FILT_US    = 16;
    localparam int unsigned WAKE_FILT_CYC   = (WAKE_FILT_US * (CLK_HZ / 1_000_000));
    localparam int unsigned FO_PERIOD_CYC   = 1000;

    // ============================================================
    // Register addresses (7-bit frame address)
    localparam logic [6:0] ADDR_PIN_FN   = 7'h17;
    localparam logic [6:0] ADDR_DUTY_ONE = 7'h18;
    localparam logic [6:0] ADDR_DUTY_TWO = 7'h19;
    localparam logic [6:0] ADDR_FREQ     = 7'h1C;
    localparam logic [6:0] ADDR_SCRATCH  = 7'h1E;
    localparam logic [6:0] ADDR_EVT_STAT = 7'h40;

    // ============================================================
    // Reset values and field positions
    localparam logic [7:0] RST_CFG           = 8'h00;
    localparam logic [7:0] EVT_STAT_CLR_MASK = 8'hFF;
    localparam int unsigned FN_FO_DUTY_LSB   = 6;
    localparam int unsigned FN_PIN2_LSB      = 3;
    localparam int unsigned FN_PIN1_LSB      = 0;
    localparam int unsigned FREQ_ONE_BIT     = 0;
    localparam int unsigned FREQ_TWO_BIT     = 2;
    localparam int unsigned FRAME_MODE_BIT   = 7;
    localparam int unsigned FRAME_DATA_LSB   = 8;
    localparam logic [4:0] FRAME_BITS        = 5'h10;
    localparam logic [4:0] FRAME_ADDR_BITS   = 5'h08;

    // ============================================================
    // Function codes
    localparam logic [2:0] PIN2_OFF      = 3'h4;
    localparam logic [2:0] PIN2_WAKE     = 3'h5;
    localparam logic [2:0] PIN2_LOW_ON   = 3'h6;
    localparam logic [2:0] PIN2_HIGH_ON  = 3'h7;
    localparam logic [2:0] HS_SEL_PWM_ONE = 3'h4;
    localparam logic [2:0] HS_SEL_PWM_TWO = 3'h5;
    localparam int unsigned NUM_HS       = 4;

    // Fail-output on-time divisors for 20 %, 10 %, 5 % and 2.5 %.
    localparam int unsigned FO_DIV_0 = 5;
    localparam int unsigned FO_DIV_1 = 10;
    localparam int unsigned FO_DIV_2 = 20;
    localparam int unsigned FO_DIV_3 = 40;

endpackage : spg_pkg

// ### spg_pwm_chan.sv
// One free-running 8-bit duty PWM channel with 200 / 400 Hz period select.
module spg_pwm_chan #(
    parameter int unsigned STEP_LO_CYC = spg_pkg::PWM_STEP_LO_CYC,
    parameter int unsigned STEP_HI_CYC = spg_pkg::PWM_STEP_HI_CYC
) (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic [7:0] duty,
    input  wire logic       rate_sel,
    output logic            pwm_out
);
    import spg_pkg::*;

    // ============================================================
    // Elaboration checks
    if (STEP_LO_CYC < 1 || STEP_HI_CYC < 1 || STEP_LO_CYC > 65535 || STEP_HI_CYC > 65535) begin : g_chk
        $error("spg_pwm_chan: step counts must lie in 1..65535");
    end

    logic [15:0] pre_q;
    logic [15:0] pre_d;
    logic [7:0]  step_q;
    logic [7:0]  step_d;
    logic [15:0] pre_top;
    logic        step_tick;

    // ============================================================
    // Step prescaler: a period is 255 steps, so the rate select picks the step length.
    assign pre_top   = rate_sel ? 16'(STEP_HI_CYC - 1) : 16'(STEP_LO_CYC - 1);
    assign step_tick = (pre_q >= pre_top);
    assign pre_d     = step_tick ? 16'h0000 : pre_q + 16'h0001;
    assign step_d    = !step_tick ? step_q : (step_q == 8'hFE) ? 8'h00 : step_q + 8'h01;

    // Counter and output flop; the output is a register so it never glitches.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pre_q   <= 16'h0000;
            step_q  <= 8'h00;
            pwm_out <= 1'b0;
        end else begin
            pre_q   <= pre_d;
            step_q  <= step_d;
            pwm_out <= (step_q < duty);
        end
    end

    // ============================================================
    // Assertions
    property p_duty_zero_off;
        @(posedge clk_sys) disable iff (rst)
        (duty == 8'h00) |=> !pwm_out;
    endproperty
    a_duty_zero_off: assert property (p_duty_zero_off) else $error("PWM high with zero duty.");

    property p_duty_full_on;
        @(posedge clk_sys) disable iff (rst)
        (duty == 8'hFF) |=> pwm_out;
    endproperty
    a_duty_full_on: assert property (p_duty_full_on) else $error("PWM low with full duty.");

    property p_step_bound;
        @(posedge clk_sys) disable iff (rst)
        (step_q <= 8'hFE) && (pre_q <= pre_top || $changed(rate_sel) || $past(rate_sel) != rate_sel);
    endproperty
    a_step_bound: assert property (p_step_bound) else $error("PWM step counter out of range.");

endmodule : spg_pwm_chan

// ### spg_top.sv
// Switch PWM, fail-output and pin-function configuration with its 16-bit serial register port.
//
// Notes on behaviour
// - Fail duty field codes 00,01,10,11 give 20, 10, 5 and 2.5 percent.
// - Second pin codes 000 to 011 carry the fail output; 100 leaves it off.
// - Second pin code 101 is filtered wake input, 110 low-side on, 111 high-side on.
// - First PWM duty: zero fully off, 255 fully on, else N/255 on.
// - Second PWM runs independently with the same duty encoding.
// - Rate bit 0 (first) and bit 2 (second): clear 200 Hz, set 400 Hz.
// - Reserved rate register bits read zero and ignore writes.
// - Pin-function, duty and rate registers clear on power-on and soft reset only.
// - Scratch byte clears on power-on reset only, surviving soft reset.
// - Scratch byte accessible only in normal mode; hardware never changes it.
// - Fail-safe or restart mode leaves the scratch byte untouched.
// - Each access is a 16-bit frame: 7-bit address, mode bit, data byte.
// - Data bits D0 to D7 sit at frame bits 8 to 15.
// - Status access with mode bit zero returns the byte unchanged.
// - Status access with mode bit one returns the byte, then clears clearable bits.
// - Status flags stay set until cleared over the serial port or by soft reset.
// - High-side selector 100 takes the first PWM, 101 the second.
module spg_top #(
    parameter int unsigned STEP_LO_CYC = spg_pkg::PWM_STEP_LO_CYC,
    parameter int unsigned STEP_HI_CYC = spg_pkg::PWM_STEP_HI_CYC,
    parameter int unsigned FO_PERIOD   = spg_pkg::FO_PERIOD_CYC
) (
    input  wire logic                          clk_sys,
    input  wire logic                          rst,
    input  wire logic                          spi_csn_n,
    input  wire logic                          spi_sclk,
    input  wire logic                          spi_sdi,
    output logic                               spi_sdo,
    output logic                               spi_sdo_oe,
    input  wire logic                          normal_mode,
    input  wire logic                          soft_rst_req,
    input  wire logic                          fail_active,
    input  wire logic [3*spg_pkg::NUM_HS-1:0]  hs_select,
    input  wire logic [7:0]                    event_set,
    input  wire logic                          wake_pin,
    output logic                               pwm_one_out,
    output logic                               pwm_two_out,
    output logic [spg_pkg::NUM_HS-1:0]         hs_pwm_drive,
    output logic [2:0]                         first_pin_function,
    output logic                               second_pin_fo_out,
    output logic                               second_pin_ls_on,
    output logic                               second_pin_hs_on,
    output logic                               wake_level,
    output logic                               wake_evt
);
    import spg_pkg::*;

    // ============================================================
    // Elaboration checks
    if (FO_PERIOD < FO_DIV_3 || FO_PERIOD > 65535) begin : g_chk
        $error("spg_top: FO_PERIOD must lie in 40..65535");
    end

    // ============================================================
    // Pin synchronisers: three stages, a level counts once stages two and three agree.
    logic [3:0] pin_s1_q;
    logic [3:0] pin_s2_q;
    logic [3:0] pin_s3_q;
    logic [3:0] pin_f_q;
    logic [3:0] pin_raw;

    assign pin_raw = {wake_pin, spi_sdi, spi_sclk, spi_csn_n};

    // Stage one feeds only stage two; the agreement test reads stages two and three.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pin_s1_q <= 4'h1;  // Idle levels, so no false clock or wake edge follows reset.
            pin_s2_q <= 4'h1;
            pin_s3_q <= 4'h1;
            pin_f_q  <= 4'h1;
        end else begin
            pin_s1_q <= pin_raw;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            pin_f_q  <= (pin_s2_q & ~(pin_s2_q ^ pin_s3_q)) | (pin_f_q & (pin_s2_q ^ pin_s3_q));
        end
    end

    logic cs_fall;
    logic cs_rise;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_act;

    assign cs_act    = !pin_f_q[0];
    assign cs_fall   = pin_f_q[0] && !pin_s2_q[0] && !pin_s3_q[0];
    assign cs_rise   = !pin_f_q[0] && pin_s2_q[0] && pin_s3_q[0];
    assign sclk_rise = cs_act && !pin_f_q[1] && pin_s2_q[1] && pin_s3_q[1];
    assign sclk_fall = cs_act && pin_f_q[1] && !pin_s2_q[1] && !pin_s3_q[1];

    // ============================================================
    // Frame shifter: bits arrive least significant first, bit n into position n.
    logic [15:0] rx_q;
    logic [15:0] tx_q;
    logic [4:0]  bit_cnt_q;
    logic [7:0]  rd_data;
    logic [6:0]  frm_addr;
    logic        frm_mode;
    logic [7:0]  frm_data;
    logic        frm_done;

    assign frm_addr = rx_q[6:0];
    assign frm_mode = rx_q[FRAME_MODE_BIT];
    assign frm_data = rx_q[FRAME_DATA_LSB +: 8];
    assign frm_done = cs_rise && (bit_cnt_q == FRAME_BITS);

    // The read byte is latched on the edge that takes the mode bit, so it reflects
    // the register before any clear or write of this same frame.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rx_q      <= 16'h0000;
            tx_q      <= 16'h0000;
            bit_cnt_q <= 5'h00;
            spi_sdo   <= 1'b0;
        end else if (cs_fall) begin
            rx_q      <= 16'h0000;
            tx_q      <= 16'h0000;
            bit_cnt_q <= 5'h00;
            spi_sdo   <= 1'b0;
        end else if (sclk_rise && bit_cnt_q < FRAME_BITS) begin
            rx_q[bit_cnt_q[3:0]] <= pin_f_q[2];
            bit_cnt_q            <= bit_cnt_q + 5'h01;
            if (bit_cnt_q == FRAME_ADDR_BITS - 5'h01) begin
                tx_q[FRAME_DATA_LSB +: 8] <= rd_data;
            end
        end else if (sclk_fall && bit_cnt_q < FRAME_BITS) begin
            spi_sdo <= tx_q[bit_cnt_q[3:0]];
        end
    end

    assign spi_sdo_oe = cs_act;

    // ============================================================
    // Register decode. Mode bit one marks a write on configuration registers.
    logic [7:0] pin_fn_q;
    logic [7:0] duty_one_q;
    logic [7:0] duty_two_q;
    logic [1:0] rate_q;
    logic [7:0] scratch_q;
    logic [7:0] evt_q;
    logic [7:0] rate_rd;
    logic       wr_cfg;
    logic       wr_pin_fn;
    logic       wr_duty_one;
    logic       wr_duty_two;
    logic       wr_rate;
    logic       wr_scratch;
    logic       clr_evt;

    assign wr_cfg      = frm_done && frm_mode;
    assign wr_pin_fn   = wr_cfg && (frm_addr == ADDR_PIN_FN);
    assign wr_duty_one = wr_cfg && (frm_addr == ADDR_DUTY_ONE);
    assign wr_duty_two = wr_cfg && (frm_addr == ADDR_DUTY_TWO);
    assign wr_rate     = wr_cfg && (frm_addr == ADDR_FREQ);
    assign wr_scratch  = wr_cfg && (frm_addr == ADDR_SCRATCH) && normal_mode;
    assign clr_evt     = wr_cfg && (frm_addr == ADDR_EVT_STAT);

    // Reserved rate bits are not stored and read back as zero.
    assign rate_rd = {5'h00, rate_q[1], 1'b0, rate_q[0]};

    // Read mux; unmapped addresses and a locked scratch byte answer zero.
    assign rd_data = (frm_addr == ADDR_PIN_FN)   ? pin_fn_q :
                     (frm_addr == ADDR_DUTY_ONE) ? duty_one_q :
                     (frm_addr == ADDR_DUTY_TWO) ? duty_two_q :
                     (frm_addr == ADDR_FREQ)     ? rate_rd :
                     (frm_addr == ADDR_SCRATCH)  ? (normal_mode ? scratch_q : 8'h00) :
                     (frm_addr == ADDR_EVT_STAT) ? evt_q : 8'h00;

    // Configuration registers: cleared by power-on and soft reset, kept through restart.
    always_ff @(posedge clk_sys) begin
        if (rst || soft_rst_req) begin
            pin_fn_q   <= RST_CFG;
            duty_one_q <= RST_CFG;
            duty_two_q <= RST_CFG;
            rate_q     <= 2'b00;
        end else begin
            if (wr_pin_fn) pin_fn_q <= frm_data;
            if (wr_duty_one) duty_one_q <= frm_data;
            if (wr_duty_two) duty_two_q <= frm_data;
            if (wr_rate) rate_q <= {frm_data[FREQ_TWO_BIT], frm_data[FREQ_ONE_BIT]};
        end
    end

    // Scratch byte: only power-on reset and a normal-mode write change it; soft
    // reset, fail-safe and restart have no path in.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            scratch_q <= RST_CFG;
        end else if (wr_scratch) begin
            scratch_q <= frm_data;
        end
    end

    // Sticky event status: a new event in the clearing cycle survives the clear.
    always_ff @(posedge clk_sys) begin
        if (rst || soft_rst_req) begin
            evt_q <= RST_CFG;
        end else begin
            evt_q <= (evt_q & ~(clr_evt ? EVT_STAT_CLR_MASK : 8'h00)) | event_set;
        end
    end

    // ============================================================
    // PWM channels and high-side routing
    spg_pwm_chan #(
        .STEP_LO_CYC (STEP_LO_CYC),
        .STEP_HI_CYC (STEP_HI_CYC)
    ) u_pwm_one (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .duty     (duty_one_q),
        .rate_sel (rate_q[0]),
        .pwm_out  (pwm_one_out)
    );

    spg_pwm_chan #(
        .STEP_LO_CYC (STEP_LO_CYC),
        .STEP_HI_CYC (STEP_HI_CYC)
    ) u_pwm_two (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .duty     (duty_two_q),
        .rate_sel (rate_q[1]),
        .pwm_out  (pwm_two_out)
    );

    for (genvar g = 0; g < NUM_HS; g++) begin : g_hs
        assign hs_pwm_drive[g] = ((hs_select[3*g +: 3] == HS_SEL_PWM_ONE) && pwm_one_out) ||
                                 ((hs_select[3*g +: 3] == HS_SEL_PWM_TWO) && pwm_two_out);
    end

    // ============================================================
    // Fail-output modulator and second pin function
    logic [1:0]  fo_duty;
    logic [2:0]  pin2_fn;
    logic [15:0] fo_cnt_q;
    logic [15:0] fo_on;
    logic        pin2_is_fo;

    assign fo_duty            = pin_fn_q[FN_FO_DUTY_LSB +: 2];
    assign pin2_fn            = pin_fn_q[FN_PIN2_LSB +: 3];
    assign first_pin_function = pin_fn_q[FN_PIN1_LSB +: 3];
    assign pin2_is_fo         = !pin2_fn[2];
    assign fo_on = (fo_duty == 2'b00) ? 16'(FO_PERIOD / FO_DIV_0) :
                   (fo_duty == 2'b01) ? 16'(FO_PERIOD / FO_DIV_1) :
                   (fo_duty == 2'b10) ? 16'(FO_PERIOD / FO_DIV_2) : 16'(FO_PERIOD / FO_DIV_3);

    // The fail output blinks at a fixed period with the chosen on share.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            fo_cnt_q          <= 16'h0000;
            second_pin_fo_out <= 1'b0;
            second_pin_ls_on  <= 1'b0;
            second_pin_hs_on  <= 1'b0;
        end else begin
            fo_cnt_q          <= (fo_cnt_q >= 16'(FO_PERIOD - 1)) ? 16'h0000 : fo_cnt_q + 16'h0001;
            second_pin_fo_out <= pin2_is_fo && fail_active && (fo_cnt_q < fo_on);
            second_pin_ls_on  <= (pin2_fn == PIN2_LOW_ON);
            second_pin_hs_on  <= (pin2_fn == PIN2_HIGH_ON);
        end
    end

    // ============================================================
    // Wake input static filter: a new level must hold for the full filter time.
    logic [11:0] wk_cnt_q;
    logic        wake_en;

    assign wake_en = (pin2_fn == PIN2_WAKE);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wk_cnt_q   <= 12'h000;
            wake_level <= 1'b0;
            wake_evt   <= 1'b0;
        end else begin
            wake_evt <= 1'b0;
            if (!wake_en || pin_f_q[3] == wake_level) begin
                wk_cnt_q <= 12'h000;
            end else if (wk_cnt_q >= 12'(WAKE_FILT_CYC - 1)) begin
                wk_cnt_q   <= 12'h000;
                wake_level <= pin_f_q[3];
                wake_evt   <= 1'b1;
            end else begin
                wk_cnt_q <= wk_cnt_q + 12'h001;
            end
        end
    end

    // ============================================================
    // Assertions
    property p_scratch_keeps;
        @(posedge clk_sys) disable iff (rst)
        !wr_scratch |=> $stable(scratch_q);
    endproperty
    a_scratch_keeps: assert property (p_scratch_keeps) else $error("Scratch byte changed without a write.");

    property p_scratch_locked;
        @(posedge clk_sys) disable iff (rst)
        !normal_mode |=> $stable(scratch_q);
    endproperty
    a_scratch_locked: assert property (p_scratch_locked) else $error("Scratch write outside normal mode.");

    property p_soft_clears_cfg;
        @(posedge clk_sys) disable iff (rst)
        soft_rst_req |=> (pin_fn_q == 8'h00) && (duty_one_q == 8'h00) && (rate_rd == 8'h00);
    endproperty
    a_soft_clears_cfg: assert property (p_soft_clears_cfg) else $error("Soft reset left configuration set.");

    property p_rate_reserved_zero;
        @(posedge clk_sys) disable iff (rst)
        (rate_rd & 8'hFA) == 8'h00;
    endproperty
    a_rate_reserved_zero: assert property (p_rate_reserved_zero) else $error("Reserved rate bit read set.");

    property p_evt_set_wins;
        @(posedge clk_sys) disable iff (rst || soft_rst_req)
        (event_set != 8'h00) |=> ((evt_q & $past(event_set)) == $past(event_set));
    endproperty
    a_evt_set_wins: assert property (p_evt_set_wins) else $error("Status event lost.");

    property p_evt_read_keeps;
        @(posedge clk_sys) disable iff (rst || soft_rst_req)
        !clr_evt |=> ((evt_q & $past(evt_q)) == $past(evt_q));
    endproperty
    a_evt_read_keeps: assert property (p_evt_read_keeps) else $error("Status bit dropped without a clear.");

    property p_evt_clear;
        @(posedge clk_sys) disable iff (rst || soft_rst_req)
        (clr_evt && event_set == 8'h00) |=> ((evt_q & EVT_STAT_CLR_MASK) == 8'h00);
    endproperty
    a_evt_clear: assert property (p_evt_clear) else $error("Read-clear left a bit set.");

    property p_pin2_off;
        @(posedge clk_sys) disable iff (rst)
        (pin2_fn == PIN2_OFF) [*2] |-> !second_pin_fo_out && !second_pin_ls_on && !second_pin_hs_on;
    endproperty
    a_pin2_off: assert property (p_pin2_off) else $error("Second pin active while off.");

    property p_hs_route;
        @(posedge clk_sys) disable iff (rst)
        (hs_select[5:3] == HS_SEL_PWM_TWO) |-> (hs_pwm_drive[1] == pwm_two_out);
    endproperty
    a_hs_route: assert property (p_hs_route) else $error("High-side switch not following second PWM.");

    property p_frame_write;
        @(posedge clk_sys) disable iff (rst || soft_rst_req)
        (frm_done && frm_mode && frm_addr == ADDR_DUTY_ONE) |=> (duty_one_q == $past(frm_data));
    endproperty
    a_frame_write: assert property (p_frame_write) else $error("Duty write not taken from data byte.");

endmodule : spg_top

// ### spg_host.sv
// Host controller model that shifts 16-bit register frames into the block.
module spg_host (
    input  wire logic clk_sys,
    output logic      spi_csn_n,
    output logic      spi_sclk,
    output logic      spi_sdi,
    input  wire logic spi_sdo
);
    timeunit 1ns;
    timeprecision 1ps;

    // ============================================================
    // Idle levels; the clock stands low outside frames.
    initial begin
        spi_csn_n = 1'b1;
        spi_sclk  = 1'b0;
        spi_sdi   = 1'b0;
    end

    // One whole frame, bit 0 first, the clock low for 16 and high for 8 system clocks per bit.
    // The reply bit is taken at the edge that raises the clock, before the pin moves.
    task automatic xfer(input logic [15:0] f, output logic [15:0] r);
        spi_csn_n <= 1'b0;
        for (int n = 0; n < 16; n++) begin
            repeat (8) @(posedge clk_sys);
            spi_sdi <= f[n];
            repeat (8) @(posedge clk_sys);
            spi_sclk <= 1'b1;
            r[n] = spi_sdo;
            repeat (8) @(posedge clk_sys);
            spi_sclk <= 1'b0;
        end
        repeat (8) @(posedge clk_sys);
        spi_csn_n <= 1'b1;
        // Invert the data line so a stale bit never looks valid.
        spi_sdi   <= ~f[15];
        repeat (12) @(posedge clk_sys);
    endtask : xfer
endmodule : spg_host

// ### testbench.sv
// Self-checking bench for the PWM and pin-function configuration block.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import spg_pkg::*;

    // ============================================================
    // Signals
    typedef struct { logic [6:0] a; logic [7:0] w; logic [7:0] e; } spg_row_t;
    logic        clk_sys, rst, normal_mode, soft_rst_req, fail_active, wake_pin;
    logic [11:0] hs_select;
    logic [7:0]  event_set;
    logic [3:0]  hs_pwm_drive;
    logic [2:0]  first_pin_function;
    logic        spi_csn_n, spi_sclk, spi_sdi, spi_sdo, spi_sdo_oe, pwm_one_out, pwm_two_out;
    logic        second_pin_fo_out, second_pin_ls_on, second_pin_hs_on, wake_level, wake_evt;
    logic        p1, p2;
    logic [15:0] rsp;
    int          errors, comparisons, c1, c2, cf, ch, r1, r2;
    spg_row_t    rows [6] = '{'{ADDR_PIN_FN, 8'hA5, 8'hA5}, '{ADDR_DUTY_ONE, 8'hC3, 8'hC3},
        '{ADDR_DUTY_TWO, 8'h3C, 8'h3C}, '{ADDR_FREQ, 8'hFF, 8'h05},
        '{ADDR_SCRATCH, 8'h5A, 8'h5A}, '{7'h20, 8'hFF, 8'h00}};

    // Short step counts keep one 200 Hz period at 510 cycles.
    spg_top #(.STEP_LO_CYC(2), .STEP_HI_CYC(1), .FO_PERIOD(40)) uut (.clk_sys, .rst, .spi_csn_n,
        .spi_sclk, .spi_sdi, .spi_sdo, .spi_sdo_oe, .normal_mode, .soft_rst_req, .fail_active,
        .hs_select, .event_set, .wake_pin, .pwm_one_out, .pwm_two_out, .hs_pwm_drive,
        .first_pin_function, .second_pin_fo_out, .second_pin_ls_on, .second_pin_hs_on,
        .wake_level, .wake_evt);
    spg_host host (.clk_sys, .spi_csn_n, .spi_sclk, .spi_sdi, .spi_sdo);

    // ============================================================
    // Tasks
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        host.xfer({d, 1'b1, a}, rsp);
    endtask : wr
    task automatic rd(input logic [6:0] a);
        host.xfer({8'h00, 1'b0, a}, rsp);
    endtask : rd
    task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_reg
    task automatic chk_cnt(input int got, input int exp);
        comparisons++;
        if (got != exp) begin
            errors++;
            $display("wrong value at %0t: count %0d expected %0d", $time, got, exp);
        end
    endtask : chk_cnt
    // Settle past any period in flight, then count high cycles and rising edges over a whole span.
    // Edge counts tell the two rates apart, which equal high counts over full periods cannot.
    task automatic cnt(input int cyc);
        c1 = 0; c2 = 0; cf = 0; ch = 0;
        r1 = 0; r2 = 0;
        repeat (520) @(posedge clk_sys);
        p1 = pwm_one_out;
        p2 = pwm_two_out;
        repeat (cyc) begin
            @(posedge clk_sys);
            c1 += (pwm_one_out === 1'b1);
            c2 += (pwm_two_out === 1'b1);
            cf += (second_pin_fo_out === 1'b1);
            ch += (hs_pwm_drive[0] === 1'b1);
            r1 += (pwm_one_out === 1'b1 && p1 === 1'b0);
            r2 += (pwm_two_out === 1'b1 && p2 === 1'b0);
            p1 = pwm_one_out;
            p2 = pwm_two_out;
        end
    endtask : cnt
    task automatic wrap_up;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : wrap_up

    // ============================================================
    // Clock and watchdog; the run needs about 30000 cycles.
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (80000) @(posedge clk_sys);
        errors++;
        $display("wrong value at %0t: watchdog", $time);
        wrap_up();
    end

    // ============================================================
    // Main sequence.
    initial begin
        rst = 1'b1; normal_mode = 1'b1; soft_rst_req = 1'b0; fail_active = 1'b0;
        wake_pin = 1'b0; hs_select = 12'h000; event_set = 8'h00;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (8) @(posedge clk_sys);
        // Before any frame the data pin is released and no wake has been seen.
        chk_reg({13'h0000, spi_sdo_oe, wake_level, wake_evt}, 16'h0000);
        foreach (rows[i]) begin
            rd(rows[i].a); chk_reg(rsp, 16'h0000);
        end
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w); rd(rows[i].a);
            chk_reg(rsp, {rows[i].e, 8'h00});
        end
        $display("test registers done");
        soft_rst_req <= 1'b1;
        @(posedge clk_sys) soft_rst_req <= 1'b0;
        repeat (4) @(posedge clk_sys);
        foreach (rows[i]) begin
            rd(rows[i].a); chk_reg(rsp, {(rows[i].a == ADDR_SCRATCH) ? 8'h5A : 8'h00, 8'h00});
        end
        normal_mode <= 1'b0;
        wr(ADDR_SCRATCH, 8'h11); rd(ADDR_SCRATCH); chk_reg(rsp, 16'h0000);
        normal_mode <= 1'b1;
        rd(ADDR_SCRATCH); chk_reg(rsp, 16'h5A00);
        $display("test soft reset and scratch done");
        event_set <= 8'h81;
        @(posedge clk_sys) event_set <= 8'h00;
        rd(ADDR_EVT_STAT); chk_reg(rsp, 16'h8100);
        rd(ADDR_EVT_STAT); chk_reg(rsp, 16'h8100);
        host.xfer({8'h00, 1'b1, ADDR_EVT_STAT}, rsp); chk_reg(rsp, 16'h8100);
        rd(ADDR_EVT_STAT); chk_reg(rsp, 16'h0000);
        $display("test status done");
        hs_select <= 12'h02C;
        wr(ADDR_DUTY_ONE, 8'h80); wr(ADDR_DUTY_TWO, 8'h40); cnt(510);
        chk_cnt(c1, 256); chk_cnt(c2, 128); chk_cnt(ch, 256);
        chk_cnt(r1, 1); chk_cnt(r2, 1); chk_cnt(cf, 0);
        wr(ADDR_FREQ, 8'h01); cnt(510);
        chk_cnt(c1, 256); chk_cnt(c2, 128);
        chk_cnt(r1, 2); chk_cnt(r2, 1);
        wr(ADDR_DUTY_ONE, 8'hFF); wr(ADDR_DUTY_TWO, 8'h00); cnt(510);
        chk_cnt(c1, 510); chk_cnt(c2, 0); chk_reg({12'h000, hs_pwm_drive}, 16'h0001);
        $display("test pwm done");
        // Switch 2 takes a timer, since the wake filter is selected below.
        fail_active <= 1'b1;
        hs_select <= 12'h0AC;
        for (int k = 0; k < 8; k++) begin
            wr(ADDR_PIN_FN, {k[1:0], k[2:0], 3'h5}); cnt(40);
            chk_cnt(cf, (k < 4) ? (8 >> k) : 0);
            chk_reg({11'h000, second_pin_ls_on, second_pin_hs_on, first_pin_function},
                {11'h000, k == 6, k == 7, 3'h5});
        end
        // A new wake level must hold the whole filter time before it is taken.
        wr(ADDR_PIN_FN, 8'h28);
        wake_pin <= 1'b1;
        repeat (3980) @(posedge clk_sys);
        chk_reg({15'h0000, wake_level}, 16'h0000);
        ch = 0;
        repeat (60) begin
            @(posedge clk_sys);
            ch += (wake_evt === 1'b1);
        end
        chk_reg({15'h0000, wake_level}, 16'h0001);
        chk_cnt(ch, 1);
        $display("test pin function done");
        wrap_up();
    end
endmodule : testbench
